// file: logic/pcmp_port.sv
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pcmp_consts.svh"
// Functional notes
// - Playback 16-192kHz, sense 8-192kHz rates accepted.
// - Both directions disabled powers whole port down.
// - Slower sense samples repeat in output frames.
// - I2S/LJ: two channels, ratio twice channel.
// - Drop extra input LSBs, pad output LSBs.
// - Falling frame clock starts channel 0 default.
// - I2S MSB second edge, LJ first edge.
// - Selectable active bit edge for capture, launch.
// - Frame edge select; transitions on inactive edge.
// - TDM inputs equal ratio over channel length.
// - TDM output in 8-bit slots, ratio/8.
// - TDM rising sync default, polarity selectable.
// - TDM MSB on first, second, third edge.
// - Mono mixer passes or averages two channels.
// - Receive disabled feeds zero to playback.
// - Bypass path selects channel, else zero.
// - Transmit enable; two channels or 64 slots.
// - Long sense words lose trailing bits.
// - TDM types span two to four slots.
// - Idle or disabled slots float or zero.

module pcmp_port (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_bit_clk,
  input wire logic i_frame_clk,
  input wire logic i_ser_din,
  output logic o_ser_dout,
  output logic o_ser_dout_oe,
  input wire logic [15:0] i_vsense,
  input wire logic [15:0] i_isense,
  input wire logic [31:0] i_monitor,
  input wire logic i_sense_valid,
  output logic [31:0] o_play_data,
  output logic [31:0] o_bypass_data,
  output logic o_sample_valid
);

  // Length in bits of a word or channel length code.
  function automatic logic [5:0] len_of(input logic [1:0] code);
    len_of = (code == `PCMP_L16) ? `PCMP_N16 : (code == `PCMP_L24) ? `PCMP_N24 : `PCMP_N32;
  endfunction

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  pcmp_pkg::pcmp_ctrl_t ctrl_r, ctrl_nxt;
  pcmp_pkg::pcmp_fmt_t fmt_r, fmt_nxt;
  pcmp_pkg::pcmp_mix_t mix_r, mix_nxt;
  pcmp_pkg::pcmp_tmap_t [2:0] map_r, map_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] rdata_nxt;
  logic port_on;
  logic [9:0] flen_r;
  logic [31:0] play_r;

  assign port_on = ctrl_r.rx_en | ctrl_r.tx_en;

  // Zero wait states: reads are decoded in the address phase so the data
  // stands for the whole data phase; writes land in the data phase.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    fmt_nxt = fmt_r;
    mix_nxt = mix_r;
    map_nxt = map_r;
    wr_nxt = i_hsel & (i_htrans == `PCMP_AHB_NONSEQ) & i_hready & i_hwrite;
    wa_nxt = i_haddr[7:0];
    rdata_nxt = o_hrdata;
    if (wr_r)
    begin
      unique case (wa_r)
        `PCMP_A_CTRL: ctrl_nxt = i_hwdata[15:0];
        `PCMP_A_FMT: fmt_nxt = {i_hwdata[25:16], 9'h000, i_hwdata[6:0]};
        `PCMP_A_MIX: mix_nxt = i_hwdata[11:0];
        `PCMP_A_TXMAP: map_nxt = {i_hwdata[22:16], i_hwdata[14:8], i_hwdata[6:0]};
        default: ;
      endcase
    end
    if (i_hsel & (i_htrans == `PCMP_AHB_NONSEQ) & i_hready & ~i_hwrite)
    begin
      unique case (i_haddr[7:0])
        `PCMP_A_CTRL: rdata_nxt = {16'h0000, ctrl_r};
        `PCMP_A_FMT: rdata_nxt = {6'h00, fmt_r};
        `PCMP_A_MIX: rdata_nxt = {20'h00000, mix_r};
        `PCMP_A_TXMAP: rdata_nxt = {9'h000, map_r[2], 1'b0, map_r[1], 1'b0, map_r[0]};
        `PCMP_A_STAT: rdata_nxt = {6'h00, flen_r, 15'h0000, port_on};
        `PCMP_A_PLAY: rdata_nxt = play_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Bus registers; the slave never stalls and always answers OKAY.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      ctrl_r <= `PCMP_RST_CTRL;
      fmt_r <= `PCMP_RST_FMT;
      mix_r <= `PCMP_RST_MIX;
      map_r <= `PCMP_RST_MAP;
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else if (i_ce)
    begin
      ctrl_r <= ctrl_nxt;
      fmt_r <= fmt_nxt;
      mix_r <= mix_nxt;
      map_r <= map_nxt;
      wr_r <= wr_nxt;
      wa_r <= wa_nxt;
      o_hrdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Link pin synchroniser and edge finder
  // ---------------------------------------------------------------
  pcmp_pkg::pcmp_link_t s1_r, s2_r;
  logic bclk_d_r;
  logic act;
  logic tdm;
  logic [1:0] msb_ofs;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      bclk_d_r <= 1'b0;
    end
    else if (i_ce)
    begin
      s1_r <= {i_bit_clk, i_frame_clk, i_ser_din};
      s2_r <= s1_r;
      bclk_d_r <= s2_r.bclk;
    end
  end

  // Active edge is rising when the select is low, falling when high.
  assign act = port_on & (ctrl_r.active_bit_edge_sel ? (bclk_d_r & ~s2_r.bclk)
                                                     : (~bclk_d_r & s2_r.bclk));
  assign tdm = fmt_r.format >= `PCMP_F_TDM0;
  // Active edges between the frame edge and the first MSB.
  assign msb_ofs = (fmt_r.format == `PCMP_F_I2S) ? 2'h1 :
                   (fmt_r.format == `PCMP_F_LJ) ? 2'h0 :
                   2'(fmt_r.format - `PCMP_F_TDM0);

  // ---------------------------------------------------------------
  // Framing and receive
  // ---------------------------------------------------------------
  logic lr_last_r, lr_last_nxt;
  logic [9:0] bpos_r, bpos_nxt, flen_nxt;
  logic [5:0] bic_r, bic_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic [31:0] sh_r, sh_nxt, wa_w_r, wa_w_nxt, wb_w_r, wb_w_nxt, wy_r, wy_nxt;
  logic [31:0] play_nxt, byp_nxt, sword;
  logic fstart, want_rise, vld_nxt;
  logic [5:0] wlen, clen;
  logic [32:0] mixsum;

  assign wlen = len_of(fmt_r.word_length_sel);
  assign clen = len_of(fmt_r.chan_len_sel);
  // Frame clock is looked at only on active edges, so its transitions must
  // fall on inactive edges; channel 0 begins on the selected edge.
  assign want_rise = tdm ^ ctrl_r.frame_edge_polarity_sel;
  assign fstart = act & (want_rise ? (~lr_last_r & s2_r.lrclk) : (lr_last_r & ~s2_r.lrclk));
  assign sword = {sh_r[30:0], s2_r.din};
  assign mixsum = {wa_w_r[31], wa_w_r} + {wb_w_r[31], wb_w_r};

  // Bit position, channel counters, input shift and mixer.
  always_comb
  begin
    lr_last_nxt = lr_last_r;
    bpos_nxt = bpos_r;
    flen_nxt = flen_r;
    bic_nxt = bic_r;
    ch_nxt = ch_r;
    sh_nxt = sh_r;
    wa_w_nxt = wa_w_r;
    wb_w_nxt = wb_w_r;
    wy_nxt = wy_r;
    play_nxt = play_r;
    byp_nxt = o_bypass_data;
    vld_nxt = 1'b0;
    if (act)
    begin
      lr_last_nxt = s2_r.lrclk;
      bpos_nxt = fstart ? 10'h000 : 10'(bpos_r + 10'h001);
      if (fstart)
      begin
        flen_nxt = 10'(bpos_r + 10'h001);
        vld_nxt = 1'b1;
        // Mixer output is taken once per frame from the held channel words.
        if (!ctrl_r.rx_en)
          play_nxt = 32'h00000000;
        else if (ctrl_r.mono_mixer_setup)
          play_nxt = mixsum[32:1];
        else
          play_nxt = wa_w_r;
        byp_nxt = ctrl_r.byp_en ? wy_r : 32'h00000000;
      end
      // Channel count follows ratio / channel length on its own.
      if (bpos_nxt == 10'(msb_ofs))
      begin
        bic_nxt = 6'h00;
        ch_nxt = 5'h00;
      end
      else if (bic_r == 6'(clen - 6'h01))
      begin
        bic_nxt = 6'h00;
        ch_nxt = (ch_r == 5'h1F) ? ch_r : 5'(ch_r + 5'h01);
      end
      else
        bic_nxt = 6'(bic_r + 6'h01);
      // The last channel's tail may spill past the next frame edge when the
      // MSB sits late, so capture is not gated by the frame position.
      if (bic_nxt < wlen)
      begin
        sh_nxt = sword;
        // Last kept bit: left-align the word, lower channel bits are ignored.
        if (bic_nxt == 6'(wlen - 6'h01) && !ch_nxt[4])
        begin
          if (ch_nxt[3:0] == mix_r.mixer_first_input_sel)
            wa_w_nxt = sword << (`PCMP_N32 - wlen);
          if (ch_nxt[3:0] == mix_r.mixer_second_input_sel)
            wb_w_nxt = sword << (`PCMP_N32 - wlen);
          if (ch_nxt[3:0] == mix_r.bypass_src_sel)
            wy_nxt = sword << (`PCMP_N32 - wlen);
        end
      end
    end
  end

  // Framing state; all of it is held clear while the port is down.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || (i_ce && !port_on))
    begin
      lr_last_r <= 1'b0;
      bpos_r <= 10'h000;
      flen_r <= 10'h000;
      bic_r <= 6'h00;
      ch_r <= 5'h00;
      sh_r <= 32'h00000000;
      wa_w_r <= 32'h00000000;
      wb_w_r <= 32'h00000000;
      wy_r <= 32'h00000000;
      play_r <= 32'h00000000;
      o_play_data <= 32'h00000000;
      o_bypass_data <= 32'h00000000;
      o_sample_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      lr_last_r <= lr_last_nxt;
      bpos_r <= bpos_nxt;
      flen_r <= flen_nxt;
      bic_r <= bic_nxt;
      ch_r <= ch_nxt;
      sh_r <= sh_nxt;
      wa_w_r <= wa_w_nxt;
      wb_w_r <= wb_w_nxt;
      wy_r <= wy_nxt;
      play_r <= play_nxt;
      o_play_data <= play_nxt;
      o_bypass_data <= byp_nxt;
      o_sample_valid <= vld_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Transmit
  // ---------------------------------------------------------------
  logic [31:0] held_r [`PCMP_NTYPE];
  logic [31:0] held_nxt [`PCMP_NTYPE];
  logic [31:0] frm_r [`PCMP_NTYPE];
  logic [31:0] frm_nxt [`PCMP_NTYPE];
  logic [5:0] twid [`PCMP_NTYPE];
  logic dout_nxt, oe_nxt, hit, hbit, idle_drive;
  logic [9:0] npos, dpos;
  logic [5:0] tb, toff;
  logic [6:0] slot;

  // Sense and monitor words are left-aligned; widths in bits.
  assign twid[0] = `PCMP_N16;
  assign twid[1] = `PCMP_N16;
  assign twid[2] = `PCMP_N32;

  // The launch at each active edge carries the bit for the following one,
  // so that the output is settled when the host samples it.
  always_comb
  begin
    held_nxt = held_r;
    frm_nxt = frm_r;
    dout_nxt = o_ser_dout;
    oe_nxt = o_ser_dout_oe;
    hit = 1'b0;
    hbit = 1'b0;
    tb = 6'h00;
    toff = 6'h00;
    slot = 7'h00;
    // Sense words are held until the converter gives new ones, so a slow
    // converter repeats its sample in every frame until then.
    if (i_sense_valid)
    begin
      held_nxt[0] = {i_vsense, 16'h0000};
      held_nxt[1] = {i_isense, 16'h0000};
      held_nxt[2] = i_monitor;
    end
    if (fstart)
      frm_nxt = held_r;
    npos = 10'(bpos_nxt + 10'h001);
    if (npos >= fmt_r.bits_per_frame_ratio)
      npos = 10'h000;
    dpos = 10'(npos - 10'(msb_ofs));
    idle_drive = ~ctrl_r.idle_slot_float_sel;
    if (npos < 10'(msb_ofs))
    begin
      hit = 1'b0;
    end
    else if (tdm)
    begin
      slot = dpos[9:3];
      for (int k = 0; k < `PCMP_NTYPE; k++)
      begin
        toff = 6'(dpos - {1'b0, map_r[k].slot, 3'h0});
        if (map_r[k].en && slot <= `PCMP_SLOT_MAX && slot >= {1'b0, map_r[k].slot}
            && {1'b0, slot - {1'b0, map_r[k].slot}} < {2'h0, twid[k][5:`PCMP_SLOT_BITS]})
        begin
          hit = 1'b1;
          hbit = frm_r[k][5'(6'd31 - toff)];
        end
      end
    end
    else
    begin
      slot = (dpos >= 10'(clen)) ? 7'h01 : 7'h00;
      tb = (dpos >= 10'(clen)) ? 6'(dpos - 10'(clen)) : dpos[5:0];
      for (int k = 0; k < `PCMP_NTYPE; k++)
      begin
        if (map_r[k].en && {1'b0, map_r[k].slot} == slot && dpos < 10'({clen, 1'b0}))
        begin
          hit = 1'b1;
          if (tb >= wlen)
            hbit = 1'b0;
          else if (tb < twid[k])
            hbit = frm_r[k][5'(6'd31 - tb)];
        end
      end
      // Channel bits beyond the word are pad bits, zero or floating.
      if (hit && tb >= wlen && ctrl_r.pad_bits_float_sel)
        hit = 1'b0;
      else if (hit && tb >= wlen)
        hbit = 1'b0;
      if (!hit && tb >= wlen && dpos < 10'({clen, 1'b0}))
        idle_drive = ~ctrl_r.pad_bits_float_sel;
    end
    if (act)
    begin
      dout_nxt = hit ? hbit : 1'b0;
      oe_nxt = ctrl_r.tx_en & (hit | idle_drive);
    end
  end

  // Transmit registers; the pin floats while the port is down.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || (i_ce && !ctrl_r.tx_en))
    begin
      o_ser_dout <= 1'b0;
      o_ser_dout_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ser_dout <= dout_nxt;
      o_ser_dout_oe <= oe_nxt;
    end
    if (i_sys_rst)
    begin
      for (int k = 0; k < `PCMP_NTYPE; k++)
      begin
        held_r[k] <= 32'h00000000;
        frm_r[k] <= 32'h00000000;
      end
    end
    else if (i_ce)
    begin
      held_r <= held_nxt;
      frm_r <= frm_nxt;
    end
  end

endmodule // pcmp_port

// file: logic/pcmp_consts.svh
`ifndef PCMP_CONSTS_SVH
`define PCMP_CONSTS_SVH
// Register byte offsets.
`define PCMP_A_CTRL 8'h00
`define PCMP_A_FMT 8'h04
`define PCMP_A_MIX 8'h08
`define PCMP_A_TXMAP 8'h0C
`define PCMP_A_STAT 8'h10
`define PCMP_A_PLAY 8'h14
// Reset values.
`define PCMP_RST_CTRL 16'h0000
`define PCMP_RST_FMT 26'h0400000
`define PCMP_RST_MIX 12'h010
`define PCMP_RST_MAP 21'h000000
// Format field codes.
`define PCMP_F_I2S 3'h0
`define PCMP_F_LJ 3'h1
`define PCMP_F_TDM0 3'h2
// Word and channel length codes and their lengths in bits.
`define PCMP_L16 2'h0
`define PCMP_L24 2'h1
`define PCMP_N16 6'h10
`define PCMP_N24 6'h18
`define PCMP_N32 6'h20
// Output data types: count, highest slot number, log2 of the slot size in bits.
`define PCMP_NTYPE 3
`define PCMP_SLOT_MAX 7'h3F
`define PCMP_SLOT_BITS 3
`define PCMP_AHB_NONSEQ 2'h2
`endif

// file: logic/pcmp_pkg.sv
package pcmp_pkg;
  // Control register fields.
  typedef struct packed {
    logic [3:0] sense_converter_rate_sel;
    logic [3:0] interface_rate_sel;
    logic mono_mixer_setup;
    logic idle_slot_float_sel;
    logic pad_bits_float_sel;
    logic frame_edge_polarity_sel;
    logic active_bit_edge_sel;
    logic byp_en;
    logic tx_en;
    logic rx_en;
  } pcmp_ctrl_t;
  // Frame format register fields.
  typedef struct packed {
    logic [9:0] bits_per_frame_ratio;
    logic [8:0] rsvd;
    logic [1:0] chan_len_sel;
    logic [1:0] word_length_sel;
    logic [2:0] format;
  } pcmp_fmt_t;
  // Mixer and bypass source selection.
  typedef struct packed {
    logic [3:0] bypass_src_sel;
    logic [3:0] mixer_second_input_sel;
    logic [3:0] mixer_first_input_sel;
  } pcmp_mix_t;
  // One output data type: enable and first slot.
  typedef struct packed {
    logic en;
    logic [5:0] slot;
  } pcmp_tmap_t;
  // Synchronised link pins.
  typedef struct packed {
    logic bclk;
    logic lrclk;
    logic din;
  } pcmp_link_t;
endpackage

// file: tb/pcmp_port_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pcmp_port_checker (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_bit_clk,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_ser_dout,
  input wire logic o_ser_dout_oe,
  input wire logic [31:0] o_play_data,
  input wire logic o_sample_valid
);
  logic bclk_r;
  logic [3:0] age_r;
  logic [3:0] age_nxt;

  // Cycles since the bit clock pin last moved; saturates so idle links stay quiet.
  always_comb
  begin
    age_nxt = (age_r == 4'hF) ? age_r : age_r + 4'h1;
    if (i_bit_clk != bclk_r)
      age_nxt = 4'h0;
  end

  // Registers the age counter and the previous pin level.
  always_ff @(posedge i_mclk)
  begin
    bclk_r <= i_bit_clk;
    age_r <= i_sys_rst ? 4'hF : age_nxt;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  ready_high_a: assert property (o_hreadyout)
    else $error("hreadyout dropped");
  resp_okay_a: assert property (!o_hresp)
    else $error("response not OKAY");
  rdata_hold_a: assert property ($changed(o_hrdata) |-> $past(i_hsel && i_htrans == 2'h2 && !i_hwrite && i_hready))
    else $error("read data moved without a read");
  valid_pulse_a: assert property (o_sample_valid |=> !o_sample_valid)
    else $error("sample valid longer than one cycle");
  valid_gap_a: assert property (o_sample_valid |=> (!o_sample_valid)[*8])
    else $error("frame starts too close");
  valid_edge_a: assert property (o_sample_valid |-> age_r <= 4'h8)
    else $error("frame start not tied to a bit clock edge");
  dout_launch_a: assert property ($changed(o_ser_dout) |-> age_r <= 4'h8)
    else $error("serial output moved away from a bit clock edge");
  reset_out_a: assert property ($fell(i_sys_rst) |-> o_play_data == 32'h0 && !o_sample_valid && !o_ser_dout_oe)
    else $error("outputs not cleared by reset");
endmodule // pcmp_port_checker

bind pcmp_port pcmp_port_checker pcmp_port_checker_i (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .i_bit_clk(i_bit_clk), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_ser_dout(o_ser_dout),
  .o_ser_dout_oe(o_ser_dout_oe), .o_play_data(o_play_data), .o_sample_valid(o_sample_valid));

// file: tb/pcmp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host clock master, two 16-bit channels, ratio 32
// ----------------------------------------
module pcmp_host_model (
  input wire logic i_go,
  input wire logic i_i2s,
  input wire logic [15:0] i_ch0,
  input wire logic [15:0] i_ch1,
  output logic o_bclk,
  output logic o_lrclk,
  output logic o_din
);
  logic [31:0] seq;

  initial
  begin
    o_bclk = 1'b0;
    o_lrclk = 1'b1;
    o_din = 1'b0;
  end

  // One frame per pass; once go drops the clocks stand still and data turns over.
  always
  begin
    wait (i_go);
    seq = i_i2s ? {i_ch1[0], i_ch0, i_ch1[15:1]} : {i_ch0, i_ch1};
    for (int k = 0; k < 32; k++)
    begin
      #62.5 o_bclk = 1'b0;
      o_lrclk = (k >= 16);
      o_din = seq[31 - k];
      #62.5 o_bclk = 1'b1;
    end
    if (!i_go)
      o_din = ~o_din;
  end
endmodule // pcmp_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "pcmp_consts.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sv = 1'b0;
  logic [15:0] vs = 16'h0;
  logic go = 1'b0;
  logic i2s = 1'b0;
  logic [15:0] ch0 = 16'h0;
  logic [15:0] ch1 = 16'h0;
  logic [31:0] dsh = 32'h0;
  logic [31:0] osh = 32'h0;
  logic [31:0] hrdata, play, byp;
  logic hrdy, hresp, bclk, lrclk, din, dout, oe, valid;
  int n_fail = 0;
  int n_compared = 0;

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #5 clk = ~clk;

  pcmp_port pcmp_port_i (.i_mclk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_bit_clk(bclk), .i_frame_clk(lrclk), .i_ser_din(din), .o_ser_dout(dout),
    .o_ser_dout_oe(oe), .i_vsense(vs), .i_isense(16'h0), .i_monitor(32'h0),
    .i_sense_valid(sv), .o_play_data(play), .o_bypass_data(byp), .o_sample_valid(valid));

  pcmp_host_model pcmp_host_model_i (.i_go(go), .i_i2s(i2s), .i_ch0(ch0), .i_ch1(ch1),
    .o_bclk(bclk), .o_lrclk(lrclk), .o_din(din));

  // The host samples the serial output where it is valid, on the active edge.
  always @(posedge bclk)
  begin
    dsh <= {dsh[30:0], dout};
    osh <= {osh[30:0], oe};
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for hready; only the watchdog ends a wait that never finishes.
  task automatic rdy;
    @(posedge clk);
    while (hrdy !== 1'b1)
    begin
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `PCMP_AHB_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Runs n frames; go drops mid-frame so the host ends cleanly.
  task automatic frames(input int n);
    go <= 1'b1;
    repeat (n * 32 - 16) @(posedge bclk);
    go <= 1'b0;
    repeat (16) @(posedge bclk);
    repeat (20) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`PCMP_A_CTRL, 32'h0);
    rd(`PCMP_A_FMT, 32'h00400000);
    rd(`PCMP_A_MIX, 32'h00000010);
    rd(`PCMP_A_TXMAP, 32'h0);
    rd(`PCMP_A_STAT, 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    wr(`PCMP_A_PLAY, 32'h12345678);
    rd(`PCMP_A_PLAY, 32'h0);
  endtask

  task automatic t_lj;
    wr(`PCMP_A_CTRL, 32'h1);
    wr(`PCMP_A_FMT, 32'h00200001);
    ch0 <= 16'h8123;
    ch1 <= 16'h4567;
    frames(3);
    chk(play, 32'h81230000);
    chk(byp, 32'h0);
    rd(`PCMP_A_STAT, 32'h00200001);
  endtask

  // Negative first input checks that the average is sign extended.
  task automatic t_mix;
    wr(`PCMP_A_MIX, 32'h110);
    wr(`PCMP_A_CTRL, 32'h85);
    wr(`PCMP_A_FMT, 32'h00200000);
    ch0 <= 16'hF000;
    ch1 <= 16'h3000;
    i2s <= 1'b1;
    frames(3);
    chk(play, 32'h10000000);
    chk(byp, 32'h30000000);
  endtask

  task automatic t_tx;
    wr(`PCMP_A_FMT, 32'h00200001);
    wr(`PCMP_A_TXMAP, 32'h40);
    wr(`PCMP_A_CTRL, 32'h2);
    i2s <= 1'b0;
    @(posedge clk);
    sv <= 1'b1;
    vs <= 16'hA5C3;
    @(posedge clk);
    sv <= 1'b0;
    frames(3);
    chk(play, 32'h0);
    chk(dsh, 32'hA5C30000);
    wr(`PCMP_A_CTRL, 32'h42);
    frames(2);
    chk(osh, 32'hFFFF0000);
  endtask

  task tally_and_finish;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence after four reset cycles.
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_lj();
    t_mix();
    t_tx();
    tally_and_finish();
  end

  // Eleven frames need about 50 us; anything far beyond that is a hang.
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule // testbench
